// *** gpd_fet_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// External MOSFET drain feedback
// ----------------------------------------
module gpd_fet_model (
	input wire pclk,
	input wire [3:0] gate,
	input wire [3:0] short_en,
	output reg [3:0] drain_fb
);
	initial drain_fb = 4'hf;
	// Drain high while off or shorted, one cycle turn-on lag
	always @(posedge pclk) begin
		drain_fb <= ~gate | short_en;
	end
endmodule // gpd_fet_model

// *** gpd_map.vh ***
`ifndef GPD_MAP_VH
`define GPD_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPD_ADDR_CTRL 8'h00
`define GPD_ADDR_FLTCFG 8'h04
`define GPD_ADDR_PWM0 8'h08
`define GPD_ADDR_PWM1 8'h0c
`define GPD_ADDR_PWM2 8'h10
`define GPD_ADDR_PWM3 8'h14
`define GPD_ADDR_STATUS 8'h18
`define GPD_ADDR_MASK 8'h1c
`define GPD_ADDR_STATE 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GPD_CTRL_ON_LSB 0
`define GPD_CTRL_PWMEN_LSB 4
`define GPD_CTRL_RETRY_LSB 8
`define GPD_CTRL_MODE_LSB 12
`define GPD_FLT_THR_LSB 0
`define GPD_FLT_TMR_LSB 3
`define GPD_PWM_DUTY_LSB 0
`define GPD_PWM_FREQ_LSB 7
`define GPD_STATE_GATE_LSB 0
`define GPD_STATE_LATCH_LSB 4
`define GPD_STATE_INH_LSB 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPD_RST_CTRL 16'h0000
`define GPD_RST_THR 3'h3
`define GPD_RST_TMR 3'h3
`define GPD_RST_DUTY 7'h00
`define GPD_RST_FREQ 3'h0
`define GPD_RST_MASK 4'h0

// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define GPD_CODE_NOCHG 2'h3
`define GPD_DUTY_FULL 7'h64
`define GPD_CLK_NS 40
`define GPD_FT_BASE_NS 30000
`define GPD_PWM_BASE_HZ 10
`define GPD_PCT_STEPS 100
`define GPD_RETRY_MULT 100

`endif

// *** gpd_pwm_fault_ctrl.v ***
// How it works
// - Timer code 0-5 picks 30 to 960 us, doubling; 6 and 7 keep it.
// - A short is detected while the gate is driven on and the drain comparator reports above threshold.
// - Short declared and gate dropped only after unbroken detection beyond timer.
// - Each channel has a retry bit; set means retry after an inhibit time.
// - Retry holds the gate off for one hundred fault-timer lengths.
// - After inhibit, gate returns only if no off request came meanwhile.
// - A repeated declaration after retry imposes another full inhibit.
// - Retry bit clear latches off until a fresh turn-on request arrives.
// - A PWM channel resumes after inhibit at the start of the next period.
// - Frequency and duty writes apply only from the next period start.
// - On/off requests to a PWM channel take effect at the period start.
// - Duty is seven bits, one percent per count, above 100 means full.
// - Frequency code 0 gives 10 Hz, doubling per step up to 1.28 kHz.
// - Without PWM, gate follows serial bit OR input; with PWM, either runs PWM.
// - Shorts hidden by too short on-times need not be flagged.
// - Threshold code 0-5 picks 0.5 to 3.0 V, default 2.0; 6 and 7 keep it.
`timescale 1ns/1ps
`include "gpd_map.vh"

module gpd_pwm_fault_ctrl #(
	parameter FT_BASE_CYC = `GPD_FT_BASE_NS / `GPD_CLK_NS,
	parameter PWM_STEP_CYC = 1000000000 / (`GPD_CLK_NS * `GPD_PWM_BASE_HZ * `GPD_PCT_STEPS),
	parameter RETRY_MULT = `GPD_RETRY_MULT
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [3:0] gate_parallel_input,
	input wire [3:0] drain_feedback_input,
	output wire [3:0] gate_drive_output,
	output reg [2:0] short_threshold_sel,
	output reg irq
);

	localparam [1:0] ST_RUN = 2'h0;
	localparam [1:0] ST_INH = 2'h1;
	localparam [1:0] ST_WAITP = 2'h2;
	localparam [1:0] ST_LATCH = 2'h3;
	localparam [15:0] FT_BASE16 = FT_BASE_CYC[15:0];
	localparam [15:0] STEP16 = PWM_STEP_CYC[15:0];
	localparam [6:0] RETRY7 = RETRY_MULT[6:0];
	// Last percent step of a period, cut to the counter width
	localparam integer PCT_LAST_I = `GPD_PCT_STEPS - 1;
	localparam [6:0] PCT_LAST = PCT_LAST_I[6:0];

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Fault timer length in cycles for a code
	function [15:0] ft_cycles;
		input [2:0] code;
		begin
			ft_cycles = FT_BASE16 << code;
		end
	endfunction

	// Codes 6 and 7 leave a setting as it was
	function [2:0] code_upd;
		input [2:0] cur;
		input [2:0] wr;
		begin
			if (wr[2:1] == `GPD_CODE_NOCHG) begin
				code_upd = cur;
			end else begin
				code_upd = wr;
			end
		end
	endfunction

	// Write target: PWM word of one channel
	function pwm_hit;
		input [7:0] addr;
		input [1:0] ch;
		begin
			pwm_hit = (addr == `GPD_ADDR_PWM0 + {4'h0, ch, 2'h0});
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [3:0] gin_m_q;
	reg [3:0] gin_s_q;
	reg [3:0] fb_m_q;
	reg [3:0] fb_s_q;

	// Two stages for pins from outside the clock domain
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gin_m_q <= 4'h0;
			gin_s_q <= 4'h0;
			fb_m_q <= 4'h0;
			fb_s_q <= 4'h0;
		end else begin
			gin_m_q <= gate_parallel_input;
			gin_s_q <= gin_m_q;
			fb_m_q <= drain_feedback_input;
			fb_s_q <= fb_m_q;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg [15:0] ctrl_q;
	reg [2:0] tmr_q;
	reg [6:0] duty_q [0:3];
	reg [2:0] freq_q [0:3];
	reg [3:0] status_q;
	reg [3:0] mask_q;
	wire [3:0] declare_w;
	wire [3:0] latch_w;
	wire [3:0] inh_w;
	wire [15:0] ft_lim = ft_cycles(tmr_q);
	wire setup = psel & ~penable;
	wire done = psel & penable & pready;
	wire wr_en = done & pwrite;
	wire rd_clr = done & ~pwrite & (paddr == `GPD_ADDR_STATUS);
	wire [3:0] status_d = (status_q & ~(rd_clr ? prdata[3:0] : 4'h0)) | declare_w;
	reg [31:0] rdata_d;
	reg hit_d;

	// Read mux and address decode
	always @* begin
		rdata_d = 32'h0;
		hit_d = 1'b1;
		case (paddr)
			`GPD_ADDR_CTRL: rdata_d = {16'h0, ctrl_q};
			`GPD_ADDR_FLTCFG: rdata_d = {26'h0, tmr_q, short_threshold_sel};
			`GPD_ADDR_PWM0: rdata_d = {22'h0, freq_q[0], duty_q[0]};
			`GPD_ADDR_PWM1: rdata_d = {22'h0, freq_q[1], duty_q[1]};
			`GPD_ADDR_PWM2: rdata_d = {22'h0, freq_q[2], duty_q[2]};
			`GPD_ADDR_PWM3: rdata_d = {22'h0, freq_q[3], duty_q[3]};
			`GPD_ADDR_STATUS: rdata_d = {28'h0, status_q};
			`GPD_ADDR_MASK: rdata_d = {28'h0, mask_q};
			`GPD_ADDR_STATE: rdata_d = {20'h0, inh_w, latch_w, gate_drive_output};
			default: hit_d = 1'b0;
		endcase
	end

	// Bus answer: no wait states, data captured in setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0 : rdata_d;
				pslverr <= ~hit_d;
			end else if (done) begin
				pslverr <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Sticky status and interrupt
	// ----------------------------------------
	// New declarations win over a clearing read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= 4'h0;
			irq <= 1'b0;
		end else begin
			status_q <= status_d;
			irq <= |(status_d & mask_q);
		end
	end

	// Register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `GPD_RST_CTRL;
			tmr_q <= `GPD_RST_TMR;
			short_threshold_sel <= `GPD_RST_THR;
			mask_q <= `GPD_RST_MASK;
		end else begin
			if (wr_en) begin
				case (paddr)
					`GPD_ADDR_CTRL: ctrl_q <= pwdata[15:0];
					`GPD_ADDR_FLTCFG: begin
						short_threshold_sel <= code_upd(short_threshold_sel, pwdata[2:0]);
						tmr_q <= code_upd(tmr_q, pwdata[5:3]);
					end
					`GPD_ADDR_MASK: mask_q <= pwdata[3:0];
					default: ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	// Live PWM settings, one word per channel, single writer
	integer k;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (k = 0; k < 4; k = k + 1) begin
				duty_q[k] <= `GPD_RST_DUTY;
				freq_q[k] <= `GPD_RST_FREQ;
			end
		end else begin
			for (k = 0; k < 4; k = k + 1) begin
				if (wr_en && pwm_hit(paddr, k[1:0])) begin
					duty_q[k] <= pwdata[`GPD_PWM_DUTY_LSB +: 7];
					freq_q[k] <= pwdata[`GPD_PWM_FREQ_LSB +: 3];
				end
			end
		end
	end

	// ----------------------------------------
	// Per-channel logic
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			// Controls of this channel
			wire mode = ctrl_q[`GPD_CTRL_MODE_LSB + i];
			wire pen = ctrl_q[`GPD_CTRL_PWMEN_LSB + i];
			wire retry = ctrl_q[`GPD_CTRL_RETRY_LSB + i];
			wire req = mode & (ctrl_q[`GPD_CTRL_ON_LSB + i] | gin_s_q[i]);

			// Period, fault and recovery state
			reg req_prev_q;
			reg [6:0] dsh_q;
			reg [2:0] fsh_q;
			reg [15:0] step_q;
			reg [6:0] pct_q;
			reg preq_q;
			reg [15:0] fcnt_q;
			reg [15:0] icyc_q;
			reg [6:0] inum_q;
			reg cancel_q;
			reg [1:0] st_q;
			reg gate_q;

			// Period position decode
			wire [15:0] step_lim = STEP16 >> fsh_q;
			wire step_end = (step_q == step_lim - 16'h1);
			wire wrap = step_end & (pct_q == PCT_LAST);
			wire pstart = ~pen | wrap;
			wire [6:0] duty_eff = (dsh_q > `GPD_DUTY_FULL) ? `GPD_DUTY_FULL : dsh_q;
			wire pwm_on = preq_q & (pct_q < duty_eff);
			wire want = pen ? pwm_on : req;

			// Short detection and inhibit end
			wire det = fb_s_q[i] & gate_q;
			wire decl = det & (fcnt_q == ft_lim) & (st_q == ST_RUN);
			wire icyc_end = (icyc_q == ft_lim - 16'h1);
			wire inh_end = icyc_end & (inum_q == RETRY7 - 7'h1);

			// Results back to the register file
			assign declare_w[i] = decl;
			assign latch_w[i] = (st_q == ST_LATCH);
			assign inh_w[i] = (st_q == ST_INH);
			assign gate_drive_output[i] = gate_q;

			// ----------------------------------------
			// PWM period
			// ----------------------------------------
			// PWM period: shadow settings and request at period start
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					dsh_q <= `GPD_RST_DUTY;
					fsh_q <= `GPD_RST_FREQ;
					step_q <= 16'h0;
					pct_q <= 7'h0;
					preq_q <= 1'b0;
				end else if (!pen) begin
					dsh_q <= duty_q[i];
					fsh_q <= freq_q[i];
					step_q <= 16'h0;
					pct_q <= 7'h0;
					preq_q <= req;
				end else if (step_end) begin
					step_q <= 16'h0;
					if (wrap) begin
						pct_q <= 7'h0;
						dsh_q <= duty_q[i];
						fsh_q <= freq_q[i];
						preq_q <= req;
					end else begin
						pct_q <= pct_q + 7'h1;
					end
				end else begin
					step_q <= step_q + 16'h1;
				end
			end

			// ----------------------------------------
			// Short qualification
			// ----------------------------------------
			// Fault qualification counter
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					fcnt_q <= 16'h0;
				end else if (!det || st_q != ST_RUN) begin
					fcnt_q <= 16'h0;
				end else if (fcnt_q != ft_lim) begin
					fcnt_q <= fcnt_q + 16'h1;
				end
			end

			// ----------------------------------------
			// Recovery
			// ----------------------------------------
			// Fault recovery state machine
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st_q <= ST_RUN;
					icyc_q <= 16'h0;
					inum_q <= 7'h0;
					cancel_q <= 1'b0;
					req_prev_q <= 1'b0;
					gate_q <= 1'b0;
				end else begin
					req_prev_q <= req;
					gate_q <= (st_q == ST_RUN) & want & ~decl;
					case (st_q)
						ST_RUN: begin
							if (decl) begin
								icyc_q <= 16'h0;
								inum_q <= 7'h0;
								cancel_q <= 1'b0;
								st_q <= retry ? ST_INH : ST_LATCH;
							end
						end
						ST_INH: begin
							if (!req) begin
								cancel_q <= 1'b1;
							end
							if (icyc_end) begin
								icyc_q <= 16'h0;
								inum_q <= inum_q + 7'h1;
							end else begin
								icyc_q <= icyc_q + 16'h1;
							end
							if (inh_end) begin
								if (cancel_q || !req) begin
									st_q <= ST_LATCH;
								end else begin
									st_q <= pen ? ST_WAITP : ST_RUN;
								end
							end
						end
						ST_WAITP: begin
							if (pstart) begin
								st_q <= ST_RUN;
							end
						end
						ST_LATCH: begin
							if (req && !req_prev_q) begin
								st_q <= ST_RUN;
							end
						end
						default: st_q <= ST_RUN;
					endcase
				end
			end
		end
	endgenerate

endmodule // gpd_pwm_fault_ctrl

// *** gpd_pwm_fault_ctrl_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module gpd_pwm_fault_ctrl_props #(
	parameter FT_BASE_CYC = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire [3:0] gate_parallel_input,
	input wire [3:0] drain_feedback_input,
	input wire [3:0] gate_drive_output,
	input wire [2:0] short_threshold_sel,
	input wire irq
);
	reg [15:0] hi_q;
	reg [7:0] qt_q;
	wire done = psel && penable && pready;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Drain-high run length, cycles since last command
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 16'h0000;
			qt_q <= 8'h00;
		end else begin
			hi_q <= drain_feedback_input[0] ? hi_q + (hi_q != 16'hffff) : 16'h0000;
			qt_q <= (done || $changed(gate_parallel_input[0])) ? 8'h00 : qt_q + (qt_q != 8'hff);
		end
	end
	a_ready_one_wait: assert property (psel && !penable |=> pready && penable)
		else $error("pready late");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_unmapped: assert property (pready && paddr > 8'h20 |-> pslverr)
		else $error("no pslverr");
	a_err_mapped: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("stray pslverr");
	a_thr_code_legal: assert property (short_threshold_sel < 3'h6)
		else $error("threshold code 6 or 7");
	a_thr_by_write: assert property (!$stable(short_threshold_sel) |->
		$past(done && pwrite && paddr == 8'h04))
		else $error("threshold moved alone");
	a_irq_drop_bus: assert property ($fell(irq) |-> $past(done) || $past(done, 2))
		else $error("irq fell alone");
	a_gate_short_qual: assert property ($fell(gate_drive_output[0]) && qt_q > 8'h08 |->
		hi_q >= FT_BASE_CYC)
		else $error("gate dropped early");
endmodule // gpd_pwm_fault_ctrl_props

bind gpd_pwm_fault_ctrl gpd_pwm_fault_ctrl_props #(.FT_BASE_CYC(FT_BASE_CYC)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.gate_parallel_input(gate_parallel_input), .drain_feedback_input(drain_feedback_input),
	.gate_drive_output(gate_drive_output), .short_threshold_sel(short_threshold_sel), .irq(irq));

// *** gpd_pwm_fault_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "gpd_map.vh"
module gpd_pwm_fault_ctrl_tb;
	reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg [3:0] gin = 4'h0, short_en = 4'h0;
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [3:0] gate, fb;
	wire [2:0] thr;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	int fails = 0, samples_checked = 0;
	int c, n, tl, old, hi, step;
	int dt[4] = '{12, 37, 1, 127};
	// ----------------------------------------
	// Clock, design and far side
	// ----------------------------------------
	always #20 pclk = ~pclk;
	gpd_pwm_fault_ctrl #(.FT_BASE_CYC(4), .PWM_STEP_CYC(8)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gate_parallel_input(gin), .drain_feedback_input(fb), .gate_drive_output(gate),
		.short_threshold_sel(thr), .irq(irq));
	gpd_fet_model u_fet (.pclk(pclk), .gate(gate), .short_en(short_en), .drain_fb(fb));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input [32:0] g, input [32:0] lo, input [32:0] up);
		samples_checked++;
		if (^g === 1'bx || g < lo || g > up) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, g, lo);
			fails++;
		end
	endtask
	task automatic timeout();
		fails++;
		close_out();
	endtask
	task automatic xfer(input w, input [7:0] a, input [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) timeout();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input [7:0] a, input [32:0] x);
		exp_q.push_back(x);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic wait_g(input int ch, input bit lvl, input int lim, output int cnt,
		input bit must);
		cnt = 0;
		while (gate[ch] !== lvl && cnt < lim) begin
			@(posedge pclk);
			cnt++;
		end
		if (must && cnt >= lim) timeout();
	endtask
	// Read data and error against oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = exp_q.pop_front();
			chk({pslverr, prdata}, e, e);
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		n = $urandom(9836);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`GPD_ADDR_FLTCFG, 33'h1b);
		rd(`GPD_ADDR_CTRL, 33'h0);
		rd(`GPD_ADDR_MASK, 33'h0);
		rd(8'h24, 33'h100000000);
		wr(`GPD_ADDR_FLTCFG, 32'h25);
		wr(`GPD_ADDR_FLTCFG, 32'h3e);
		rd(`GPD_ADDR_FLTCFG, 33'h25);
		chk(thr, 5, 5);
		wr(`GPD_ADDR_MASK, 32'h1);
		wr(`GPD_ADDR_CTRL, 32'h700b);
		// Timer codes, glitch rejection, latch-off
		for (c = 0; c < 6; c++) begin
			tl = 4 << c;
			wr(`GPD_ADDR_FLTCFG, c << 3 | 3);
			wait_g(0, 1, 20, n, 1);
			repeat (2) begin
				short_en[0] <= 1'b1;
				repeat ($urandom % (tl / 2) + 1) @(posedge pclk);
				short_en[0] <= 1'b0;
				repeat (8) @(posedge pclk);
			end
			chk(gate[0], 1, 1);
			short_en[0] <= 1'b1;
			wait_g(0, 0, tl + 20, n, 1);
			chk(n, tl + 1, tl + 10);
			repeat (3) @(posedge pclk);
			chk(irq, 1, 1);
			rd(`GPD_ADDR_STATUS, 33'h1);
			repeat (3) @(posedge pclk);
			chk(irq, 0, 0);
			short_en[0] <= 1'b0;
			repeat (30) @(posedge pclk);
			chk(gate[0], 0, 0);
			wr(`GPD_ADDR_CTRL, 32'h700a);
			wr(`GPD_ADDR_CTRL, 32'h700b);
		end
		// Retry with full inhibit each time
		wr(`GPD_ADDR_FLTCFG, 32'h3);
		wr(`GPD_ADDR_CTRL, 32'h710b);
		short_en[0] <= 1'b1;
		wait_g(0, 0, 40, n, 1);
		for (c = 0; c < 3; c++) begin
			if (c == 2) short_en[0] <= 1'b0;
			wait_g(0, 1, 500, n, 1);
			chk(n, 398, 408);
			wait_g(0, 0, 40, n, c < 2);
		end
		chk(gate[0], 1, 1);
		short_en[0] <= 1'b1;
		wait_g(0, 0, 40, n, 1);
		short_en[0] <= 1'b0;
		wr(`GPD_ADDR_CTRL, 32'h710a);
		wr(`GPD_ADDR_CTRL, 32'h710b);
		wait_g(0, 1, 450, n, 0);
		chk(gate[0], 0, 0);
		// Parallel input path and mode-off channel
		for (c = 0; c < 8; c++) begin
			n = $urandom;
			gin <= n[3:0];
			repeat (6) @(posedge pclk);
			chk(gate[2], n[2], n[2]);
			chk(gate[3], 0, 0);
		end
		// PWM high time, update only at period start
		wr(`GPD_ADDR_PWM1, 32'h0c);
		wr(`GPD_ADDR_CTRL, 32'h712b);
		old = 96;
		for (c = 0; c < 4; c++) begin
			step = 8 >> c;
			hi = dt[c] >= 100 ? 100 * step + 2 : dt[c] * step;
			wait_g(1, 0, 2000, n, 1);
			wait_g(1, 1, 2000, n, 1);
			fork
				wr(`GPD_ADDR_PWM1, c << 7 | dt[c]);
				wait_g(1, 0, 1000, n, 0);
			join
			chk(n, old - 1, old + 1);
			wait_g(1, 1, 2000, n, 1);
			wait_g(1, 0, 100 * step + 2, n, 0);
			chk(n, hi - 1, hi + 1);
			old = hi;
		end
		// PWM short: full inhibit, then back only at a period start
		wr(`GPD_ADDR_CTRL, 32'h732b);
		short_en[1] <= 1'b1;
		wait_g(1, 0, 40, n, 1);
		short_en[1] <= 1'b0;
		wait_g(1, 1, 600, n, 1);
		chk(n, 402, 501);
		rd(`GPD_ADDR_STATUS, 33'h3);
		close_out();
	end
endmodule // gpd_pwm_fault_ctrl_tb
